// file: include/bmc_params.svh
// Purpose: offsets, field positions and reset values for base memory control
// Assumes: two 32-bit register words, configuration at byte offset 0x0 and status at 0x4
// Notes: included by bare name
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH
`define BMC_CFG_OFFSET 12'h000
`define BMC_STAT_OFFSET 12'h004
`define BMC_CFG_RESET 32'h00000000
`define BMC_CFG_WMASK 32'h0fc3d1bf
`define BMC_TYPE_LSB 0
`define BMC_TYPE_MSB 1
`define BMC_DLY_BIT 2
`define BMC_EN_BIT 3
`define BMC_MUX_LSB 4
`define BMC_MUX_MSB 5
`define BMC_PAGE_BIT 7
`define BMC_CL_BIT 8
`define BMC_WIDE_BIT 12
`define BMC_SIZE_LSB 14
`define BMC_SIZE_MSB 17
`define BMC_BASE_LSB 22
`define BMC_BASE_MSB 27
`define BMC_ALIAS_BIT 28
`define BMC_RESP_OKAY 2'b00
`define BMC_RESP_SLVERR 2'b10
`endif

// file: include/bmc_pkg.sv
// Purpose: shared types for base memory control
// Assumes: nothing beyond the header
// Notes: codes of the memory type field
package bmc_pkg;
  typedef enum logic [1:0]
  {
    BMC_MEM_EDO = 2'b00,
    BMC_MEM_BAD1 = 2'b01,
    BMC_MEM_BAD2 = 2'b10,
    BMC_MEM_SDRAM = 2'b11
  } bmc_mem_t;
  typedef logic [2:0] bmc_mux_t;
endpackage

// file: logic/bmc_addr_match.sv
// Purpose: base range compare with size mask
// Assumes: combinational, same clock domain
// Notes: bit 28 never joins the compare
`timescale 1ns/1ns
`include "bmc_params.svh"
module bmc_addr_match
(
  input wire logic [31:0] cfg_in,
  input wire logic [31:0] addr_in,
  output logic hit_out
);
  logic [5:0] keep;
  logic [5:0] diff;
  // upper two compare bits always decoded, lower four per size bit
  always_comb
  begin
    keep = {2'b11, cfg_in[`BMC_SIZE_MSB:`BMC_SIZE_LSB]};
    diff = addr_in[`BMC_BASE_MSB:`BMC_BASE_LSB] ^ cfg_in[`BMC_BASE_MSB:`BMC_BASE_LSB];
    // masked bits 25:22 drop out, address bit 28 ignored
    hit_out = cfg_in[`BMC_EN_BIT] && ((diff & keep) == 6'h00);
  end
endmodule

// file: logic/bmc_wr_drain.sv
// Purpose: tracks posted write entries so reads wait for the drain
// Assumes: posted writes counted by pulses from the write path
// Notes: eight-entry count, saturates
`timescale 1ns/1ns
module bmc_wr_drain
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic post_in,
  input wire logic retire_in,
  output logic empty_out
);
  logic [3:0] cnt_q;
  // post and retire in one cycle cancel
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cnt_q <= 4'h0;
    else if (post_in && !retire_in && cnt_q != 4'h8)
      cnt_q <= cnt_q + 4'h1;
    else if (retire_in && !post_in && cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  assign empty_out = (cnt_q == 4'h0);
endmodule

// file: logic/bmc_top.sv
// Purpose: base memory control register, AXI4-Lite slave, decode controls
// Assumes: 250 MHz SYS_CLK_IN, synchronous active-high reset, same-clock memory path
// Notes: memory-side inputs come from logic on this clock, no synchronisers
// Behaviour
// - reset clears the whole configuration register to zero
// - posted write entries drain to memory before any read is serviced
// - configuration register is one word at offset zero
// - type bits 1:0 give EDO at 0, SDRAM at 3; never 1 or 2 (written codes 1 and 2 still pass through to MEM_TYPE_OUT)
// - bit 2 delays the valid strobe toward the CPU by one clock
// - bit 3 enables base memory decoding
// - bits 5:4 pick mux modes 0 to 3; SDRAM uses mode 3 (the mux select follows bits 5:4 and bit 12 whatever the type code)
// - bit 12 selects mux mode 4 and bits 5:4 are ignored
// - bit 7 keeps the page open with row strobe asserted after access
// - address bit 28 low closes the page even with page hold
// - page hold off closes the page after every access
// - bit 8 picks CAS latency for mode register: 0 gives 3, 1 gives 2
// - size bits 17:14 mask address bits 25:22, sizes 4 to 64 MB
// - size bit one keeps its address bit, zero removes it
// - address bit 28 ignored in matching, only steers page hold
// - base field compared with address bits 27:22 to detect base access
`timescale 1ns/1ns
`include "bmc_params.svh"
module bmc_top
  import bmc_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // axi4-lite slave
  input wire logic [11:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [11:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // memory access path
  input wire logic MEM_REQ_IN,
  input wire logic MEM_WRITE_IN,
  input wire logic [31:0] MEM_ADDR_IN,
  input wire logic MEM_END_IN,
  input wire logic WR_POST_IN,
  input wire logic WR_RETIRE_IN,
  input wire logic CPU_VALID_IN,
  output logic BASE_HIT_OUT,
  output logic READ_GO_OUT,
  output logic ROW_STROBE_BASE_OUT,
  output logic EXTERNAL_VALID_STROBE_OUT,
  output bmc_pkg::bmc_mem_t MEM_TYPE_OUT,
  output bmc_pkg::bmc_mux_t ADDRESS_MUX_SELECT_OUT,
  output logic [1:0] COLUMN_LATENCY_OUT,
  output logic PAGE_HOLD_ENABLE_OUT
);
  logic [31:0] cfg_q;
  logic aw_held_q;
  logic [11:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic hit;
  logic drained;
  logic page_open_q;
  logic last_hold_q;
  logic hit_q;
  logic read_go_q;
  logic external_valid_strobe_d1_q;
  logic external_valid_strobe_q;
  bmc_mem_t type_q;
  bmc_mux_t mux_q;
  logic [1:0] cl_q;
  logic hold_q;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic do_write;
  logic [31:0] status;
  logic wr_cfg_sel;
  logic wr_stat_sel;
  logic rd_cfg_sel;
  logic rd_stat_sel;

  bmc_addr_match u_match
  (
    .cfg_in(cfg_q),
    .addr_in(MEM_ADDR_IN),
    .hit_out(hit)
  );

  bmc_wr_drain u_drain
  (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .post_in(WR_POST_IN),
    .retire_in(WR_RETIRE_IN),
    .empty_out(drained)
  );

  // byte-lane merge, reserved bits forced to zero
  always_comb
  begin
    wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    merged = ((cfg_q & ~wmask) | (w_data_q & wmask)) & `BMC_CFG_WMASK;
    do_write = aw_held_q && w_held_q && !bvalid_q;
  end

  // status word shows the block's live state
  always_comb
  begin
    status = 32'h00000000;
    status[0] = page_open_q;
    status[1] = drained;
    status[2] = hit_q;
  end

  // word decode of both address channels; byte-lane bits take no part
  always_comb
  begin
    wr_cfg_sel = (aw_addr_q & 12'hffc) == `BMC_CFG_OFFSET;
    wr_stat_sel = (aw_addr_q & 12'hffc) == `BMC_STAT_OFFSET;
    rd_cfg_sel = (S_AXI_ARADDR_IN & 12'hffc) == `BMC_CFG_OFFSET;
    rd_stat_sel = (S_AXI_ARADDR_IN & 12'hffc) == `BMC_STAT_OFFSET;
  end

  // write address capture; address and data may arrive in either order
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      awready_q <= 1'b0;
    end
    else
    begin
      awready_q <= !aw_held_q && !awready_q && S_AXI_AWVALID_IN;
      if (awready_q && S_AXI_AWVALID_IN)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_IN;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      wready_q <= 1'b0;
    end
    else
    begin
      wready_q <= !w_held_q && !wready_q && S_AXI_WVALID_IN;
      if (wready_q && S_AXI_WVALID_IN)
      begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_IN;
        w_strb_q <= S_AXI_WSTRB_IN;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  // configuration register and write response
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      cfg_q <= `BMC_CFG_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= `BMC_RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        if (wr_cfg_sel)
        begin
          cfg_q <= merged;
          bresp_q <= `BMC_RESP_OKAY;
        end
        else if (wr_stat_sel)
          bresp_q <= `BMC_RESP_OKAY; // status is read-only, write ignored
        else
          bresp_q <= `BMC_RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY_IN)
        bvalid_q <= 1'b0;
    end
  end

  // read channel, one read at a time
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `BMC_RESP_OKAY;
    end
    else
    begin
      arready_q <= !arready_q && !rvalid_q && S_AXI_ARVALID_IN;
      if (arready_q && S_AXI_ARVALID_IN)
      begin
        rvalid_q <= 1'b1;
        if (rd_cfg_sel)
        begin
          rdata_q <= cfg_q; // reserved bits already zero
          rresp_q <= `BMC_RESP_OKAY;
        end
        else if (rd_stat_sel)
        begin
          rdata_q <= status;
          rresp_q <= `BMC_RESP_OKAY;
        end
        else
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= `BMC_RESP_SLVERR;
        end
      end
      else if (rvalid_q && S_AXI_RREADY_IN)
        rvalid_q <= 1'b0;
    end
  end

  // decoded controls, registered so every output is a flip-flop
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      type_q <= BMC_MEM_EDO;
      mux_q <= 3'h0;
      cl_q <= 2'h3;
      hold_q <= 1'b0;
    end
    else
    begin
      // codes 1 and 2 pass through unchanged; software must avoid them
      type_q <= bmc_mem_t'(cfg_q[`BMC_TYPE_MSB:`BMC_TYPE_LSB]);
      if (cfg_q[`BMC_WIDE_BIT])
        mux_q <= 3'h4;
      else
        mux_q <= {1'b0, cfg_q[`BMC_MUX_MSB:`BMC_MUX_LSB]};
      cl_q <= cfg_q[`BMC_CL_BIT] ? 2'h2 : 2'h3;
      hold_q <= cfg_q[`BMC_PAGE_BIT];
    end
  end

  // base hit and read release; reads wait for posted writes to drain
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      hit_q <= 1'b0;
      read_go_q <= 1'b0;
    end
    else
    begin
      hit_q <= MEM_REQ_IN && hit;
      read_go_q <= MEM_REQ_IN && !MEM_WRITE_IN && drained;
    end
  end

  // page state: remember bit 28 of the access, decide at cycle end
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      last_hold_q <= 1'b0;
      page_open_q <= 1'b0;
    end
    else
    begin
      if (MEM_REQ_IN && hit)
      begin
        last_hold_q <= cfg_q[`BMC_PAGE_BIT] && MEM_ADDR_IN[`BMC_ALIAS_BIT];
        page_open_q <= 1'b1;
      end
      else if (MEM_END_IN)
        // hold off or bit 28 low closes the page
        page_open_q <= last_hold_q && cfg_q[`BMC_PAGE_BIT];
    end
  end

  // valid strobe, optionally one extra clock late
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      external_valid_strobe_d1_q <= 1'b0;
      external_valid_strobe_q <= 1'b0;
    end
    else
    begin
      external_valid_strobe_d1_q <= CPU_VALID_IN;
      external_valid_strobe_q <= cfg_q[`BMC_DLY_BIT] ? external_valid_strobe_d1_q : CPU_VALID_IN;
    end
  end

  assign S_AXI_AWREADY_OUT = awready_q;
  assign S_AXI_WREADY_OUT = wready_q;
  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT = bresp_q;
  assign S_AXI_ARREADY_OUT = arready_q;
  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT = rdata_q;
  assign S_AXI_RRESP_OUT = rresp_q;
  assign BASE_HIT_OUT = hit_q;
  assign READ_GO_OUT = read_go_q;
  assign ROW_STROBE_BASE_OUT = page_open_q; // high = row strobe asserted
  assign EXTERNAL_VALID_STROBE_OUT = external_valid_strobe_q;
  assign MEM_TYPE_OUT = type_q;
  assign ADDRESS_MUX_SELECT_OUT = mux_q;
  assign COLUMN_LATENCY_OUT = cl_q;
  assign PAGE_HOLD_ENABLE_OUT = hold_q;
endmodule

// file: bench/bmc_top_chk_sva.sv
// Purpose: port-level checks of base memory control
// Assumes: one clock, synchronous active-high reset
// Notes: bound to bmc_top below the module
`timescale 1ns/1ns
module bmc_top_chk
(
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic MEM_REQ_IN,
  input wire logic MEM_WRITE_IN,
  input wire logic [31:0] MEM_ADDR_IN,
  input wire logic MEM_END_IN,
  input wire logic WR_POST_IN,
  input wire logic WR_RETIRE_IN,
  input wire logic CPU_VALID_IN,
  input wire logic BASE_HIT_OUT,
  input wire logic READ_GO_OUT,
  input wire logic ROW_STROBE_BASE_OUT,
  input wire logic EXTERNAL_VALID_STROBE_OUT,
  input wire bmc_pkg::bmc_mem_t MEM_TYPE_OUT,
  input wire bmc_pkg::bmc_mux_t ADDRESS_MUX_SELECT_OUT,
  input wire logic [1:0] COLUMN_LATENCY_OUT,
  input wire logic PAGE_HOLD_ENABLE_OUT
);
  import bmc_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // reset must be seen even while it is asserted
  property p_rst;
    disable iff (1'b0) SYS_RST_IN |=> MEM_TYPE_OUT == BMC_MEM_EDO && !PAGE_HOLD_ENABLE_OUT
      && COLUMN_LATENCY_OUT == 2'h3 && !ROW_STROBE_BASE_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  logic [3:0] posted_q;
  // reference count of posted entries, so a read release with writes pending is caught
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      posted_q <= 4'h0;
    else if (WR_POST_IN && !WR_RETIRE_IN && posted_q != 4'h8)
      posted_q <= posted_q + 4'h1;
    else if (WR_RETIRE_IN && !WR_POST_IN && posted_q != 4'h0)
      posted_q <= posted_q - 4'h1;
  end
  property p_go;
    READ_GO_OUT |-> $past(MEM_REQ_IN) && !$past(MEM_WRITE_IN) && $past(posted_q) == 4'h0;
  endproperty
  a_go: assert property (p_go) else $error("read go without read request");
  property p_hit;
    BASE_HIT_OUT |-> $past(MEM_REQ_IN);
  endproperty
  a_hit: assert property (p_hit) else $error("hit without request");
  property p_ev;
    EXTERNAL_VALID_STROBE_OUT |-> $past(CPU_VALID_IN) || $past(CPU_VALID_IN, 2);
  endproperty
  a_ev: assert property (p_ev) else $error("valid strobe without cause");
  property p_mux4;
    ADDRESS_MUX_SELECT_OUT[2] |-> ADDRESS_MUX_SELECT_OUT[1:0] == 2'h0;
  endproperty
  a_mux4: assert property (p_mux4) else $error("mode 4 mixed with low bits");
  property p_cl;
    COLUMN_LATENCY_OUT inside {2'h2, 2'h3};
  endproperty
  a_cl: assert property (p_cl) else $error("latency out of range");
  property p_close;
    MEM_END_IN && !PAGE_HOLD_ENABLE_OUT |-> ##[1:2] !ROW_STROBE_BASE_OUT;
  endproperty
  a_close: assert property (p_close) else $error("page left open");
  property p_a28;
    MEM_END_IN && !MEM_ADDR_IN[28] && $past(BASE_HIT_OUT) |-> ##[1:2] !ROW_STROBE_BASE_OUT;
  endproperty
  a_a28: assert property (p_a28) else $error("page open after low bit 28");
endmodule
bind bmc_top bmc_top_chk u_chk (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .MEM_REQ_IN(MEM_REQ_IN), .MEM_WRITE_IN(MEM_WRITE_IN), .MEM_ADDR_IN(MEM_ADDR_IN),
  .MEM_END_IN(MEM_END_IN), .CPU_VALID_IN(CPU_VALID_IN), .BASE_HIT_OUT(BASE_HIT_OUT),
  .WR_POST_IN(WR_POST_IN), .WR_RETIRE_IN(WR_RETIRE_IN),
  .READ_GO_OUT(READ_GO_OUT), .ROW_STROBE_BASE_OUT(ROW_STROBE_BASE_OUT),
  .EXTERNAL_VALID_STROBE_OUT(EXTERNAL_VALID_STROBE_OUT), .MEM_TYPE_OUT(MEM_TYPE_OUT),
  .ADDRESS_MUX_SELECT_OUT(ADDRESS_MUX_SELECT_OUT), .COLUMN_LATENCY_OUT(COLUMN_LATENCY_OUT),
  .PAGE_HOLD_ENABLE_OUT(PAGE_HOLD_ENABLE_OUT));

// file: bench/bmc_mem_model.sv
// Purpose: memory-side access source and write path
// Assumes: same clock as the design
// Notes: a released address shows its inverse
`timescale 1ns/1ns
module bmc_mem_model
(
  input wire logic clk_in,
  input wire logic hit_in,
  input wire logic go_in,
  input wire logic row_in,
  output logic req_out,
  output logic write_out,
  output logic [31:0] addr_out,
  output logic end_out,
  output logic post_out,
  output logic retire_out
);
  // idle levels at time zero
  initial
  begin
    {req_out, write_out, end_out, post_out, retire_out} = 5'h0;
    addr_out = 32'h0;
  end
  // address held from request to end so the page decision sees it
  task automatic access(input logic [31:0] a, input logic w, output logic h, output logic g,
    output logic r);
    @(posedge clk_in);
    req_out <= 1'b1;
    write_out <= w;
    addr_out <= a;
    @(posedge clk_in);
    req_out <= 1'b0;
    #1 h = hit_in;
    g = go_in;
    @(posedge clk_in);
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1 r = row_in;
  endtask
  // one post pulse, or one retire pulse when retire is set, after n extra cycles
  task automatic pulse(input logic retire, input logic [1:0] n);
    repeat (n) @(posedge clk_in);
    @(posedge clk_in);
    post_out <= !retire;
    retire_out <= retire;
    @(posedge clk_in);
    {post_out, retire_out} <= 2'h0;
  endtask
endmodule

// file: bench/bmc_top_tb_top.sv
// Purpose: self-checking bench for base memory control
// Assumes: 250 MHz clock, reset held 5 cycles
// Notes: random legal configurations from a fixed seed
`timescale 1ns/1ns
module bmc_top_tb_top;
  import bmc_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, cv = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, cfg, rd_d, a;
  integer seed;
  logic [1:0] bresp, rresp, rsp, cl;
  logic awr, wrdy, bv, arr, rv, req, wr, ma_end, post, ret, hit, go, rs, evs, ph, h, g, r;
  logic [31:0] maddr;
  bmc_mem_t mt;
  bmc_mux_t mux;
  int n_mismatch = 0, checked = 0, k, j, pend;
  // 4 ns period
  always #2 clk = ~clk;
  bmc_top uut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rready), .MEM_REQ_IN(req), .MEM_WRITE_IN(wr), .MEM_ADDR_IN(maddr),
    .MEM_END_IN(ma_end), .WR_POST_IN(post), .WR_RETIRE_IN(ret), .CPU_VALID_IN(cv),
    .BASE_HIT_OUT(hit), .READ_GO_OUT(go), .ROW_STROBE_BASE_OUT(rs),
    .EXTERNAL_VALID_STROBE_OUT(evs), .MEM_TYPE_OUT(mt), .ADDRESS_MUX_SELECT_OUT(mux),
    .COLUMN_LATENCY_OUT(cl), .PAGE_HOLD_ENABLE_OUT(ph));
  bmc_mem_model mem (.clk_in(clk), .hit_in(hit), .go_in(go), .row_in(rs), .req_out(req),
    .write_out(wr), .addr_out(maddr), .end_out(ma_end), .post_out(post), .retire_out(ret));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // both write channels offered together, each released when taken
  task automatic axw(input logic [11:0] ad, input logic [31:0] d, output logic [1:0] rp);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    {awv, wv, bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bv);
    rp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] ad, output logic [31:0] d, output logic [1:0] rp);
    @(posedge clk);
    araddr <= ad;
    {arv, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    d = rdata;
    rp = rresp;
    rready <= 1'b0;
  endtask
  // only legal type, mux and size codes reach the register
  function automatic logic [31:0] legal_cfg(input logic [31:0] x, input int n);
    logic [3:0] sz [5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0};
    legal_cfg = x;
    legal_cfg[1:0] = x[0] ? 2'h3 : 2'h0;
    legal_cfg[3] = (n != 1);
    if (x[0]) legal_cfg[5:4] = 2'h3;
    legal_cfg[7] = x[7] & ~x[0];
    legal_cfg[17:14] = sz[n % 5];
  endfunction
  function automatic logic hit_exp(input logic [31:0] c, input logic [31:0] ad);
    return c[3] && (((ad[27:22] ^ c[27:22]) & {2'h3, c[17:14]}) == 6'h0);
  endfunction
  // strobe lags the command valid by one clock, two when delayed
  task automatic vcheck(input logic d);
    @(posedge clk);
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    #1 chk("valid_1", !d, evs);
    @(posedge clk);
    #1 chk("valid_2", d, evs);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    seed = 32'h0e4d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axr(12'h000, rd_d, rsp);
    chk("cfg_reset", 32'h0, rd_d);
    axr(12'h010, rd_d, rsp);
    chk("unmapped_rresp", 2'h2, rsp);
    axw(12'h008, 32'hffffffff, rsp);
    chk("unmapped_bresp", 2'h2, rsp);
    for (k = 0; k < 16; k++)
    begin
      cfg = legal_cfg($random(seed), k);
      axr(12'h000, rd_d, rsp);
      axw(12'h000, cfg, rsp);
      chk("cfg_bresp", 2'h0, rsp);
      axr(12'h000, rd_d, rsp);
      // reserved 6, 11:9, 13, 21:18 and 31:28 read zero; bit 12 is kept
      chk("cfg_readback", cfg & 32'h0fc3d1bf, rd_d);
      chk("mem_type", cfg[1:0], mt);
      chk("mux_sel", cfg[12] ? 3'h4 : {1'b0, cfg[5:4]}, mux);
      chk("cas_lat", cfg[8] ? 2'h2 : 2'h3, cl);
      chk("page_hold", cfg[7], ph);
      vcheck(cfg[2]);
      for (j = 0; j < 4; j++)
      begin
        a = $random(seed);
        a[27:22] = cfg[27:22] ^ (j == 3 ? 6'h10 : {2'h0, a[5:2]});
        pend = a[7];
        if (pend) mem.pulse(1'b0, 2'h0);
        mem.access(a, a[6], h, g, r);
        chk("base_hit", hit_exp(cfg, a), h);
        chk("read_go", !a[6] && pend == 0, g);
        if (hit_exp(cfg, a)) chk("row_strobe", cfg[7] && a[28], r);
        if (pend) mem.pulse(1'b1, a[9:8]);
      end
    end
    // status: write fifo drained, no hit pending, page bit follows the row strobe
    axw(12'h004, 32'hffffffff, rsp);
    chk("status_bresp", 2'h0, rsp);
    axr(12'h004, rd_d, rsp);
    chk("status_word", {29'h0, 1'b0, 1'b1, rs}, rd_d);
    axr(12'h000, rd_d, rsp);
    chk("cfg_after_status", cfg & 32'h0fc3d1bf, rd_d);
    complete_run();
  end
endmodule
